// *** logic/iaw_pkg.sv ***
`default_nettype none

package iaw_pkg;

   // Array geometry.
   localparam int DATA_W = 32;
   localparam int ADDR_W = 10;
   localparam int DEPTH = 800;
   localparam logic [31:0] CAP_WORDS = 32'h0000_0320;
   localparam logic [31:0] LAST_INDEX = 32'h0000_031f;
   localparam logic [31:0] INDEX_STEP = 32'h0000_0001;

   // Reset values, chosen because none are given.
   localparam logic [31:0] INDEX_RST = 32'h0000_0000;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Parameter selectors as seen by the panel and the serial host.
   typedef enum logic [1:0]
   {
      IAW_SEL_CAP = 2'h0,
      IAW_SEL_IDX = 2'h1,
      IAW_SEL_WIN1 = 2'h2,
      IAW_SEL_WIN2 = 2'h3
   } iaw_sel_t;

   typedef enum logic
   {
      IAW_SRC_PANEL = 1'h0,
      IAW_SRC_COMM = 1'h1
   } iaw_src_t;

   typedef enum logic [1:0]
   {
      IAW_ST_IDLE = 2'h0,
      IAW_ST_FETCH = 2'h1,
      IAW_ST_DONE = 2'h2
   } iaw_state_t;

   // One parameter access, as a single carrier.
   typedef struct packed
   {
      iaw_src_t src;
      logic wr;
      iaw_sel_t sel;
      logic [DATA_W-1:0] wdata;
   } iaw_req_t;

endpackage : iaw_pkg

`default_nettype wire

// *** logic/iaw_array_mem.sv ***
`timescale 1ns/10ps
`default_nettype none

// Single-port store; read data appears one enabled edge after re_i.
module iaw_array_mem
   import iaw_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   input wire logic ce_i,
   // Access
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic [DATA_W-1:0] rdata_o
);

   // The contents have no reset, like the backed-up array they model.
   // shared 800-word store
   logic [DATA_W-1:0] store [0:DEPTH-1];

   always_ff @(posedge ref_clk_i)
   begin
      if (ce_i && we_i)
      begin
         store[addr_i] <= wdata_i;
      end
      if (ce_i && re_i)
      begin
         rdata_o <= store[addr_i];
      end
   end

endmodule : iaw_array_mem

`default_nettype wire

// *** logic/iaw_array_window.sv ***
// How it works
// - Array contents are reachable only through the two windows, never through capacity or index.
// - Capacity reads the array size in 32-bit words; writes are refused.
// - Index is writable and addresses the next window access.
// - Window reads return, window writes store, the element at the index.
// - Panel read of window one leaves the index unchanged.
// - Panel write of window one stores, then increments the index.
// - Serial host reads or writes through either window increment the index.
// - Panel read of window two returns the element, then increments the index.
// - Panel write of window two is refused; array and index untouched.
// - The array holds 800 shared 32-bit entries.
// - Valid index values run from zero to 799.
`timescale 1ns/10ps
`default_nettype none

module iaw_array_window
   import iaw_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Parameter access request
   input wire logic req_valid_i,
   input wire iaw_req_t req_i,
   output logic req_ready_o,
   // Answer
   output logic ack_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic err_o
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding shared by the datapath and the checks.

   function automatic logic is_window(input iaw_sel_t sel);
      is_window = (sel == IAW_SEL_WIN1) || (sel == IAW_SEL_WIN2);
   endfunction : is_window

   function automatic logic in_range(input logic [31:0] idx);
      in_range = (idx <= LAST_INDEX);
   endfunction : in_range

   function automatic logic refused(input iaw_req_t r);
      refused = (r.src == IAW_SRC_PANEL) && r.wr && (r.sel == IAW_SEL_WIN2);
   endfunction : refused

   // Only a panel read of window one skips the step; refused or out-of-range accesses never reach it.
   function automatic logic advances(input iaw_req_t r);
      advances = !((r.src == IAW_SRC_PANEL) && !r.wr
                   && (r.sel == IAW_SEL_WIN1));
   endfunction : advances

   ////////////////////////////////////////////////////////////////////////
   // State.

   iaw_state_t state;
   iaw_state_t next_state;
   logic [31:0] index;
   logic [31:0] next_index;
   logic [DATA_W-1:0] next_rdata;
   logic next_err;
   logic take;
   logic win_ok;
   logic mem_we;
   logic mem_re;
   logic [DATA_W-1:0] mem_q;

   // Both handshakes wait on ce_i, so a frozen cycle can neither take a
   // request nor give the same answer twice.
   assign req_ready_o = (state == IAW_ST_IDLE) && ce_i;
   assign ack_o = (state == IAW_ST_DONE) && ce_i;
   assign take = req_valid_i && req_ready_o;
   assign win_ok = in_range(index) && !refused(req_i);

   // the store has no port other than the window path below.
   iaw_array_mem u_mem
   (
      .ref_clk_i(ref_clk_i),
      .ce_i(ce_i),
      .we_i(mem_we),
      .re_i(mem_re),
      .addr_i(index[ADDR_W-1:0]),
      .wdata_i(req_i.wdata),
      .rdata_o(mem_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Access sequencing.

   always_comb
   begin
      next_state = state;
      next_index = index;
      next_rdata = rdata_o;
      next_err = err_o;
      mem_we = 1'b0;
      mem_re = 1'b0;
      case (state)
         IAW_ST_IDLE:
         begin
            if (take)
            begin
               next_state = IAW_ST_DONE;
               next_err = 1'b0;
               next_rdata = RDATA_RST;
               case (req_i.sel)
                  IAW_SEL_CAP:
                  begin
                     if (req_i.wr)
                     begin
                        next_err = 1'b1;
                     end
                     else
                     begin
                        next_rdata = CAP_WORDS;
                     end
                  end
                  IAW_SEL_IDX:
                  begin
                     if (req_i.wr)
                     begin
                        // All 32 bits are kept; a bad index is caught by the
                        // range check at the next window access.
                        next_index = req_i.wdata;
                     end
                     else
                     begin
                        next_rdata = index;
                     end
                  end
                  default:
                  begin
                     if (!win_ok)
                     begin
                        next_err = 1'b1;
                     end
                     else
                     begin
                        // store or fetch at the index
                        if (req_i.wr)
                        begin
                           mem_we = 1'b1;
                        end
                        else
                        begin
                           mem_re = 1'b1;
                           next_state = IAW_ST_FETCH;
                        end
                        if (advances(req_i) && (index < LAST_INDEX))
                        begin
                           // Saturates at the last element.
                           next_index = index + INDEX_STEP;
                        end
                     end
                  end
               endcase
            end
         end
         IAW_ST_FETCH:
         begin
            // element read from the old index
            next_rdata = mem_q;
            next_state = IAW_ST_DONE;
         end
         IAW_ST_DONE:
         begin
            next_state = IAW_ST_IDLE;
         end
         default:
         begin
            next_state = IAW_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state <= IAW_ST_IDLE;
         index <= INDEX_RST;
         rdata_o <= RDATA_RST;
         err_o <= 1'b0;
      end
      else if (ce_i)
      begin
         state <= next_state;
         index <= next_index;
         rdata_o <= next_rdata;
         err_o <= next_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks. The answer checks look one clock edge past the accepted request; the store checks look at the same cycle.

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   logic panel_win1_rd;
   logic win_step;
   assign panel_win1_rd = take && req_i.src == IAW_SRC_PANEL
                          && !req_i.wr && req_i.sel == IAW_SEL_WIN1;
   assign win_step = take && is_window(req_i.sel) && win_ok
                     && advances(req_i);

   a_panel_read_hold: assert property (
      panel_win1_rd |=> index == $past(index))
      else $error("Panel read of window one moved the index.");

   a_panel_write_step: assert property (
      take && req_i.src == IAW_SRC_PANEL && req_i.wr
      && req_i.sel == IAW_SEL_WIN1 && index < LAST_INDEX
      |=> index == $past(index) + 32'h1 && !err_o)
      else $error("Panel write of window one did not step the index.");

   a_comm_step: assert property (
      take && req_i.src == IAW_SRC_COMM && is_window(req_i.sel)
      && index < LAST_INDEX |=> index == $past(index) + 32'h1)
      else $error("Serial window access did not step the index.");

   a_panel_burst: assert property (
      take && req_i.src == IAW_SRC_PANEL && !req_i.wr
      && req_i.sel == IAW_SEL_WIN2 && index < LAST_INDEX
      |=> index == $past(index) + 32'h1 && state == IAW_ST_FETCH)
      else $error("Panel read of window two did not step the index.");

   a_panel_refuse: assert property (
      take && refused(req_i) |-> !mem_we ##1 err_o && $stable(index))
      else $error("Panel write of window two was not refused.");

   a_cap_readonly: assert property (
      take && req_i.sel == IAW_SEL_CAP
      |=> (err_o == $past(req_i.wr)) && (err_o || rdata_o == CAP_WORDS))
      else $error("Capacity answer wrong.");

   a_index_write: assert property (
      take && req_i.wr && req_i.sel == IAW_SEL_IDX
      |=> index == $past(req_i.wdata))
      else $error("Index write not stored.");

   a_fetch_data: assert property (
      state == IAW_ST_FETCH && ce_i |=> rdata_o == $past(mem_q)
      && state == IAW_ST_DONE)
      else $error("Window read data not returned.");

   a_range_reject: assert property (
      take && is_window(req_i.sel) && !in_range(index)
      |-> !mem_we && !mem_re ##1 err_o && $stable(index))
      else $error("Out-of-range window access not rejected.");

   a_index_ceiling: assert property (
      win_step && index == LAST_INDEX |=> index == LAST_INDEX)
      else $error("Index stepped past the last element.");

   a_store_bound: assert property (
      mem_we || mem_re |-> index <= LAST_INDEX)
      else $error("Store reached outside the array.");

   a_index_readback: assert property (
      take && !req_i.wr && req_i.sel == IAW_SEL_IDX
      |=> rdata_o == $past(index) && !err_o)
      else $error("Index readback wrong.");

   a_window_store: assert property (
      take && req_i.wr && is_window(req_i.sel) && win_ok
      |-> mem_we && !mem_re)
      else $error("Window write did not reach the store.");

   a_window_fetch: assert property (
      take && !req_i.wr && is_window(req_i.sel) && win_ok
      |-> mem_re && !mem_we ##1 state == IAW_ST_FETCH)
      else $error("Window read did not start a fetch.");

   a_write_answer: assert property (
      take && req_i.wr
      |=> rdata_o == RDATA_RST && state == IAW_ST_DONE)
      else $error("Write answer carried stale data.");

   a_answer_pulse: assert property (
      ack_o
      |=> !ack_o && state == IAW_ST_IDLE)
      else $error("Answer lasted more than one cycle.");

   a_direct_path: assert property (
      take && !is_window(req_i.sel)
      |-> !mem_we && !mem_re)
      else $error("Capacity or index access touched the store.");

   a_store_quiet: assert property (
      !take
      |-> !mem_we && !mem_re)
      else $error("Store moved without an accepted access.");

   a_comm_accept: assert property (
      take && req_i.src == IAW_SRC_COMM && is_window(req_i.sel)
      && in_range(index) |=> !err_o)
      else $error("Serial window access refused in range.");

   c_panel_burst: cover property (
      take && req_i.sel == IAW_SEL_WIN2 && !req_i.wr
      ##3 take && req_i.sel == IAW_SEL_WIN2 && !req_i.wr);
   c_comm_write: cover property (
      take && req_i.src == IAW_SRC_COMM && req_i.wr && win_ok);
   c_reject: cover property (take && refused(req_i));
   c_ceiling: cover property (win_step && index == LAST_INDEX);
   c_panel_hold: cover property (panel_win1_rd);

endmodule : iaw_array_window

`default_nettype wire

// *** dv/iaw_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module iaw_host_model
   import iaw_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   // Parameter access
   input wire logic req_ready_i,
   output logic req_valid_o,
   output iaw_req_t req_o
);
   initial
   begin
      req_valid_o = 1'b0;
      req_o = '0;
   end

   // Holds the request until ready is seen at an edge; ok low on a hang.
   task send(input iaw_req_t r, output bit ok);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      req_valid_o <= 1'b1;
      req_o <= r;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (req_ready_i !== 1'b1 && n < 64);
      ok = (req_ready_i === 1'b1);
      req_valid_o <= 1'b0;
      // Released lines change, so a stale request cannot look valid.
      req_o <= ~r;
   endtask : send
endmodule : iaw_host_model
`default_nettype wire

// *** dv/test_indexed_array_access_windows.sv ***
`timescale 1ns/10ps
`default_nettype none

module test_indexed_array_access_windows;
   import iaw_pkg::*;
   logic ref_clk_i, rst_i, ce_i, rand_ce;
   logic req_valid_i, req_ready_o, ack_o, err_o;
   iaw_req_t req_i;
   logic [DATA_W-1:0] rdata_o;
   logic [31:0] idx;
   logic [31:0] mem [int];
   logic [32:0] exp_q [$];
   int num_errors, checked;

   iaw_array_window i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .req_ready_o(req_ready_o), .ack_o(ack_o), .rdata_o(rdata_o),
      .err_o(err_o));
   iaw_host_model i_host (.ref_clk_i(ref_clk_i),
      .req_ready_i(req_ready_o), .req_valid_o(req_valid_i), .req_o(req_i));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i)
      ce_i <= rand_ce ? ($urandom_range(3) != 0) : 1'b1;

   ////////////////////////////////////////////////////////////////////////
   task tally_and_finish();
      $display("errors %0d checked %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task chk(input logic [32:0] exp, input logic [32:0] got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t exp %h got %h", $time, exp, got);
      end
   endtask : chk

   // Notes the expected {err, rdata} and then sends the access.
   task acc(input iaw_src_t s, input logic w, input iaw_sel_t sel,
      input logic [31:0] d);
      logic [32:0] e;
      bit ok;
      e = '0;
      if (sel == IAW_SEL_CAP)
         e = w ? {1'b1, 32'h0000_0000} : {1'b0, CAP_WORDS};
      else if (sel == IAW_SEL_IDX && w)
         idx = d;
      else if (sel == IAW_SEL_IDX)
         e[31:0] = idx;
      else if (idx > LAST_INDEX || (w && sel == IAW_SEL_WIN2 &&
         s == IAW_SRC_PANEL))
         e[32] = 1'b1;
      else
      begin
         if (w)
            mem[int'(idx)] = d;
         else
            e[31:0] = mem[int'(idx)];
         if (!(s == IAW_SRC_PANEL && !w && sel == IAW_SEL_WIN1) &&
            idx < LAST_INDEX)
            idx = idx + INDEX_STEP;
      end
      exp_q.push_back(e);
      i_host.send(iaw_req_t'{s, w, sel, d}, ok);
      if (!ok)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask : acc

   // index rewritten before each window access
   task win_at(input iaw_src_t s, input logic w, input iaw_sel_t sel,
      input logic [31:0] a, input logic [31:0] d);
      acc(s, 1'b1, IAW_SEL_IDX, a);
      acc(s, w, sel, d);
   endtask : win_at

   always @(posedge ref_clk_i)
      if (ack_o === 1'b1)
      begin
         if (exp_q.size() > 0)
            chk(exp_q.pop_front(), {err_o, rdata_o});
         else
            num_errors++;
      end

   initial
   begin
      #200us;
      num_errors++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'hf19b9061));
      rst_i = 1'b1;
      rand_ce = 1'b0;
      idx = '0;
      num_errors = 0;
      checked = 0;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      acc(IAW_SRC_PANEL, 1'b0, IAW_SEL_CAP, '0);
      acc(IAW_SRC_COMM, 1'b1, IAW_SEL_CAP, 32'h0000_0005);
      acc(IAW_SRC_COMM, 1'b0, IAW_SEL_CAP, '0);
      acc(IAW_SRC_PANEL, 1'b1, IAW_SEL_IDX, 32'h0000_000b);
      repeat (3) acc(IAW_SRC_PANEL, 1'b1, IAW_SEL_WIN1, $urandom);
      acc(IAW_SRC_PANEL, 1'b1, IAW_SEL_WIN2, $urandom);
      acc(IAW_SRC_PANEL, 1'b0, IAW_SEL_IDX, '0);
      acc(IAW_SRC_PANEL, 1'b1, IAW_SEL_IDX, 32'h0000_000b);
      repeat (2) acc(IAW_SRC_PANEL, 1'b0, IAW_SEL_WIN1, '0);
      repeat (3) acc(IAW_SRC_PANEL, 1'b0, IAW_SEL_WIN2, '0);
      acc(IAW_SRC_PANEL, 1'b0, IAW_SEL_IDX, '0);
      for (int k = 0; k < 4; k++)
         win_at(IAW_SRC_COMM, !k[0], k[1] ? IAW_SEL_WIN2 : IAW_SEL_WIN1,
            32'h0000_0014, $urandom);
      acc(IAW_SRC_COMM, 1'b0, IAW_SEL_IDX, '0);
      win_at(IAW_SRC_COMM, 1'b1, IAW_SEL_WIN1, LAST_INDEX - 1, $urandom);
      repeat (2) acc(IAW_SRC_COMM, 1'b1, IAW_SEL_WIN2, $urandom);
      acc(IAW_SRC_COMM, 1'b0, IAW_SEL_IDX, '0);
      win_at(IAW_SRC_COMM, 1'b0, IAW_SEL_WIN1, LAST_INDEX, '0);
      win_at(IAW_SRC_COMM, 1'b0, IAW_SEL_WIN1, CAP_WORDS, '0);
      win_at(IAW_SRC_PANEL, 1'b1, IAW_SEL_WIN1, 32'hffff_ffff, 1);
      // Random phase stays inside pre-filled elements 0 to 7.
      for (int k = 0; k < 8; k++)
         win_at(IAW_SRC_COMM, 1'b1, IAW_SEL_WIN1, k, $urandom);
      rand_ce = 1'b1;
      for (int k = 0; k < 60; k++)
         win_at(iaw_src_t'($urandom_range(1)), 1'($urandom_range(1)),
            iaw_sel_t'(2 + $urandom_range(1)), $urandom_range(7),
            $urandom);
      rand_ce = 1'b0;
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      idx = '0;
      acc(IAW_SRC_PANEL, 1'b0, IAW_SEL_IDX, '0);
      repeat (8) @(posedge ref_clk_i);
      if (exp_q.size() != 0)
         num_errors++;
      tally_and_finish();
   end
endmodule : test_indexed_array_access_windows
`default_nettype wire
